// *** hw/ioxp_pkg.sv ***
// shared types and constants for the quasi-bidirectional i/o expander
package ioxp_pkg;
    localparam logic [7:0] IOXP_PORT_RST = 8'hFF;
    localparam logic [3:0] IOXP_UPPER_BASE = 4'h4;
    localparam logic [3:0] IOXP_UPPER_ALT = 4'h7;
    localparam logic [3:0] IOXP_BYTE_BITS = 4'h8;
    localparam logic [3:0] IOXP_CNT_RST = 4'h0;

    typedef enum logic [2:0] {
        IOXP_IDLE,
        IOXP_ADDR,
        IOXP_ADDR_ACK,
        IOXP_WR_DATA,
        IOXP_WR_ACK,
        IOXP_RD_DATA,
        IOXP_RD_ACK,
        IOXP_IGNORE
    } ioxp_st_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        ioxp_st_t st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rw;
        logic [7:0] port_q;
        logic [7:0] snap_q;
        logic [7:0] accel;
        logic sda_oe_n;
        logic sda_o;
        logic [7:0] pin_oe_n;
        logic [7:0] pin_o;
        logic alert_oe_n;
        logic alert_o;
    } ioxp_state_t;
endpackage

// *** hw/ioxp_expander.sv ***
// two-wire bus slave driving an 8-bit quasi-bidirectional port
//
// Contract
// - three straps give low address bits
// - address lsb: 1 reads, 0 writes
// - upper four bits fixed by variant parameter
// - one 8-bit port register, no pointer
// - reads return live pin levels
// - port bits high after power-up
// - written 0 keeps strong pull-down on
// - written 1 pulls up strongly for ack high
// - ack address and data, apply byte at ack
// - unlimited write bytes, each replaces port
// - read acks address, resamples per acked byte
// - no buffering of pin changes between reads
// - stop keeps last port, drops partial data
// - reset initialises state machine and port
// - alert low when pins differ from capture
// - alert releases on return or port access
// - read alert clears at address ack, read strobe
`timescale 1ns/100ps
module ioxp_expander import ioxp_pkg::*; #(
    parameter bit ALT_VARIANT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic addr_strap_2,
    input wire logic [7:0] io_pin_i,
    output logic [7:0] io_pin_o,
    output logic [7:0] io_pin_oe_n,
    output logic alert_o,
    output logic alert_oe_n
);
    localparam logic [3:0] FIXED_ADDR_UPPER = ALT_VARIANT ? IOXP_UPPER_ALT : IOXP_UPPER_BASE;

    logic [1:0] rst_s_q;
    logic rst_sync_n;
    ioxp_state_t q, d;
    logic scl_rise, scl_fall, start_ev, stop_ev, addr_hit;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s_q <= 2'h0;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_s_q[1];

    // edges found on the second sync stage against its own delayed copy
    assign scl_rise = q.scl_s2 & ~q.scl_p;
    assign scl_fall = ~q.scl_s2 & q.scl_p;
    assign start_ev = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
    assign stop_ev = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
    assign addr_hit = (q.shreg[7:1] == {FIXED_ADDR_UPPER, q.strap_s2});

    always_comb begin
        d = q;
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_p = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;
        d.pin_s1 = io_pin_i;
        d.pin_s2 = q.pin_s1;
        d.strap_s1 = {addr_strap_2, addr_strap_1, addr_strap_0};
        d.strap_s2 = q.strap_s1;
        // alert follows the live compare, so a pin that reverts releases it
        d.alert_oe_n = (q.pin_s2 == q.snap_q);
        if (start_ev) begin
            d.st = IOXP_ADDR;
            d.cnt = IOXP_CNT_RST;
            d.sda_oe_n = 1'b1;
            d.accel = 8'h00;
        end else if (stop_ev) begin
            d.st = IOXP_IDLE;
            d.sda_oe_n = 1'b1;
            d.accel = 8'h00;
        end else begin
            case (q.st)
                IOXP_ADDR, IOXP_WR_DATA: begin
                    if (scl_rise) begin
                        d.shreg = {q.shreg[6:0], q.sda_s2};
                        d.cnt = 4'(q.cnt + 4'h1);
                    end else if (scl_fall && q.cnt == IOXP_BYTE_BITS) begin
                        if (q.st == IOXP_WR_DATA) begin
                            d.sda_oe_n = 1'b0;
                            d.st = IOXP_WR_ACK;
                        end else if (addr_hit) begin
                            d.sda_oe_n = 1'b0;
                            d.rw = q.shreg[0];
                            d.st = IOXP_ADDR_ACK;
                        end else begin
                            d.st = IOXP_IGNORE;
                        end
                    end
                end
                IOXP_ADDR_ACK: begin
                    if (scl_rise && q.rw) begin
                        d.shreg = q.pin_s2;
                        d.snap_q = q.pin_s2;
                    end else if (scl_fall) begin
                        d.cnt = IOXP_CNT_RST;
                        d.sda_oe_n = q.rw ? q.shreg[7] : 1'b1;
                        d.st = q.rw ? IOXP_RD_DATA : IOXP_WR_DATA;
                    end
                end
                IOXP_WR_ACK: begin
                    if (scl_rise) begin
                        d.port_q = q.shreg;
                        d.accel = q.shreg;
                        d.snap_q = q.pin_s2;
                    end else if (scl_fall) begin
                        // accelerator only for the high half of the ack clock
                        d.accel = 8'h00;
                        d.sda_oe_n = 1'b1;
                        d.cnt = IOXP_CNT_RST;
                        d.st = IOXP_WR_DATA;
                    end
                end
                IOXP_RD_DATA: begin
                    if (scl_rise) begin
                        d.cnt = 4'(q.cnt + 4'h1);
                    end else if (scl_fall) begin
                        if (q.cnt == IOXP_BYTE_BITS) begin
                            d.sda_oe_n = 1'b1;
                            d.st = IOXP_RD_ACK;
                        end else begin
                            d.shreg = {q.shreg[6:0], 1'b1};
                            d.sda_oe_n = q.shreg[6];
                        end
                    end
                end
                IOXP_RD_ACK: begin
                    if (scl_rise) begin
                        if (q.sda_s2) begin
                            d.st = IOXP_IGNORE;
                        end else begin
                            d.shreg = q.pin_s2;
                            d.snap_q = q.pin_s2;
                        end
                    end else if (scl_fall) begin
                        d.cnt = IOXP_CNT_RST;
                        d.sda_oe_n = q.shreg[7];
                        d.st = IOXP_RD_DATA;
                    end
                end
                default: begin
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end
        d.pin_o = d.port_q;
        d.pin_oe_n = ~(~d.port_q | d.accel);
        d.sda_o = 1'b0;
        d.alert_o = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q <= '0;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_p <= 1'b1;
            q.pin_s1 <= IOXP_PORT_RST;
            q.pin_s2 <= IOXP_PORT_RST;
            q.st <= IOXP_IDLE;
            q.port_q <= IOXP_PORT_RST;
            q.snap_q <= IOXP_PORT_RST;
            q.sda_oe_n <= 1'b1;
            q.pin_o <= IOXP_PORT_RST;
            q.pin_oe_n <= 8'hFF;
            q.alert_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sda_o = q.sda_o;
    assign sda_oe_n = q.sda_oe_n;
    assign io_pin_o = q.pin_o;
    assign io_pin_oe_n = q.pin_oe_n;
    assign alert_o = q.alert_o;
    assign alert_oe_n = q.alert_oe_n;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_addr_done;
        q.st == IOXP_ADDR && !start_ev && !stop_ev && scl_fall && q.cnt == IOXP_BYTE_BITS;
    endsequence
    sequence s_wr_ack_rise;
        q.st == IOXP_WR_ACK && !start_ev && !stop_ev && scl_rise;
    endsequence
    sequence s_rd_addr_rise;
        q.st == IOXP_ADDR_ACK && q.rw && !start_ev && !stop_ev && scl_rise;
    endsequence

    AST_ADDR_ACK: assert property (s_addr_done ##0 addr_hit |=> q.st == IOXP_ADDR_ACK && !q.sda_oe_n)
        else $error("own address not acknowledged");
    AST_ADDR_FOREIGN: assert property (s_addr_done ##0 !addr_hit |=> q.st == IOXP_IGNORE && q.sda_oe_n)
        else $error("foreign address acknowledged");
    AST_RW_SELECT: assert property (s_addr_done ##0 addr_hit |=> q.rw == $past(q.shreg[0]))
        else $error("operation bit mislatched");
    AST_WRITE_APPLY: assert property (s_wr_ack_rise |=> q.port_q == $past(q.shreg) ##1 io_pin_o == $past(q.shreg, 2))
        else $error("written byte not applied to port");
    AST_LOW_DRIVE: assert property ((~q.port_q & q.pin_oe_n) == 8'h00 && (q.pin_o == q.port_q))
        else $error("port zero without strong pull-down");
    AST_ACCEL_WINDOW: assert property (q.accel != 8'h00 |-> q.st == IOXP_WR_ACK && q.scl_p)
        else $error("accelerator active outside ack high");
    AST_READ_SAMPLE: assert property (s_rd_addr_rise |=> q.shreg == $past(q.pin_s2) && q.snap_q == $past(q.pin_s2))
        else $error("read byte not sampled from pins");
    AST_STOP_KEEP: assert property (stop_ev && !start_ev |=> q.st == IOXP_IDLE && $stable(q.port_q) && q.sda_oe_n)
        else $error("stop disturbed port or bus");
    AST_ALERT_SET: assert property (q.pin_s2 != q.snap_q && $stable(q.snap_q) |=> !alert_oe_n)
        else $error("alert missing on pin change");
endmodule

// *** verif/ioxp_bus_master.sv ***
// two-wire bus master model facing the expander
`timescale 1ns/100ps
module ioxp_bus_master (
    input wire logic ref_clk,
    output logic scl,
    output logic sda_rel,
    input wire logic sda_wire
);
    // clock idles high between frames; 4 ref_clk per phase gives a 400 ns period
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // s=1: start or repeated start, s=0: stop
    task automatic cond(input logic s);
        tick(1);
        sda_rel <= s;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_rel <= ~s;
        tick(4);
        scl <= ~s;
    endtask
    // data moves just after scl fall, sampled mid high phase
    task automatic bitx(input logic b, output logic r);
        tick(1);
        sda_rel <= b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        @(negedge ref_clk);
        r = sda_wire;
        tick(2);
        scl <= 1'b0;
    endtask
    // msb first, then ninth bit; ack_m high releases the line
    task automatic xfer(input logic [7:0] tx, input logic ack_m, output logic [7:0] rx, output logic ack_s);
        for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], rx[i]);
        end
        bitx(ack_m, ack_s);
    endtask
    // frame helpers keep the bus conventions in one place
    task automatic begin_frame();
        cond(1'b1);
    endtask
    task automatic end_frame();
        cond(1'b0);
    endtask
    // master sends a byte and leaves the ack slot to the slave
    task automatic wbyte(input logic [7:0] tx, output logic ack_s);
        logic [7:0] rx;
        xfer(tx, 1'b1, rx, ack_s);
    endtask
    // master releases data for a slave byte, nacks only the last one
    task automatic rbyte(input logic last, output logic [7:0] rx);
        logic ack_s;
        xfer(8'hFF, last, rx, ack_s);
    endtask
endmodule

// *** verif/i2c_quasi_bidir_io_expander_tb_top.sv ***
// self-checking bench for the quasi-bidirectional expander
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module i2c_quasi_bidir_io_expander_tb_top import ioxp_pkg::*; ();
    logic clk, rst_n, scl, sda_rel, sda_o, sda_oe_n, al_o, al_oe_n, ack;
    logic [2:0] strap;
    logic [7:0] ext, pin_o, pin_oe_n, rx;
    int n_errors = 0, n_checks = 0, port_m = 255;
    wire logic sda_w = sda_rel & (sda_oe_n | sda_o);
    // strong drive wins over the external source
    wire logic [7:0] pin = (~pin_oe_n & pin_o) | (pin_oe_n & ext);
    ioxp_expander dut_u (.ref_clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
        .io_pin_i(pin), .io_pin_o(pin_o), .io_pin_oe_n(pin_oe_n), .alert_o(al_o), .alert_oe_n(al_oe_n));
    ioxp_bus_master m (.ref_clk(clk), .scl(scl), .sda_rel(sda_rel), .sda_wire(sda_w));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_al(input logic v);
        for (int i = 0; i < 20 && al_oe_n !== v; i++) begin
            @(negedge clk);
        end
        `CHK("alert drive", 1'b0, al_o)
        `CHK("alert", v, al_oe_n)
        if (al_oe_n !== v) report_and_stop();
    endtask
    task automatic wr(input logic [6:0] a, input int nb, input logic [7:0] d);
        logic hit;
        hit = (a == {IOXP_UPPER_BASE, strap});
        m.begin_frame();
        m.wbyte({a, 1'b0}, ack);
        `CHK("wr ack", ~hit, ack)
        for (int k = 0; k < nb; k++) begin
            m.wbyte(d, ack);
            @(posedge clk);
            @(negedge clk);
            `CHK("data ack", ~hit, ack)
            if (hit) begin
                port_m = d;
                `CHK("accel", 8'h00, pin_oe_n)
            end
            `CHK("port", port_m[7:0], pin_o)
            repeat (5) @(negedge clk);
            `CHK("drive", port_m[7:0], pin_oe_n)
            d = 8'($urandom);
        end
        m.end_frame();
    endtask
    task automatic rd(input int nb);
        logic [7:0] e, nx;
        e = port_m[7:0] & ext;
        m.begin_frame();
        m.wbyte({IOXP_UPPER_BASE, strap, 1'b1}, ack);
        `CHK("rd ack", 1'b0, ack)
        for (int i = 0; i < nb; i++) begin
            nx = (i + 1 < nb) ? 8'($urandom) : ext;
            // a pulse between two samples must not show up
            fork
                m.rbyte(i + 1 == nb, rx);
                begin
                    repeat (16) @(posedge clk);
                    ext <= ~nx;
                    repeat (16) @(posedge clk);
                    ext <= nx;
                end
            join
            `CHK("rd data", e, rx)
            e = port_m[7:0] & nx;
        end
        m.end_frame();
    endtask
    initial begin
        rst_n = 1'b0;
        strap = 3'h0;
        ext = 8'hFF;
        void'($urandom(89579));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("rst port", IOXP_PORT_RST, pin_o)
        `CHK("rst drive", 8'hFF, pin_oe_n)
        repeat (8) @(posedge clk);
        for (int s = 0; s < 8; s++) begin
            strap <= 3'(s);
            ext <= 8'($urandom);
            repeat (4) @(posedge clk);
            wr({IOXP_UPPER_BASE, 3'(s)}, 2, 8'($urandom));
            wr({IOXP_UPPER_BASE, 3'(s + 1)}, 1, 8'($urandom));
            rd(2);
        end
        // stop in mid-byte leaves the port alone
        m.begin_frame();
        m.wbyte({IOXP_UPPER_BASE, strap, 1'b0}, ack);
        for (int i = 0; i < 4; i++) begin
            m.bitx(~port_m[i], ack);
        end
        m.end_frame();
        `CHK("partial", port_m[7:0], pin_o)
        wr({IOXP_UPPER_BASE, strap}, 1, 8'hFF);
        rd(1);
        wait_al(1'b1);
        @(posedge clk) ext <= ext ^ 8'h10;
        wait_al(1'b0);
        @(posedge clk) ext <= ext ^ 8'h10;
        wait_al(1'b1);
        @(posedge clk) ext <= ext ^ 8'h04;
        wait_al(1'b0);
        rd(1);
        wait_al(1'b1);
        report_and_stop();
    end
endmodule
